// ---- rtl/lpi_i2c_slave.sv ----
// Purpose: Byte-wide serial-bus slave with a register pointer.
// Assumes: sclIn and sdaIn are already synchronised to clk_sys.
// Notes:   First written byte after the address sets the pointer; it then auto-increments.
`timescale 1ns/1ps
module lpi_i2c_slave (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       reset,
	// Bus lines, synchronised
	input  wire logic       sclIn,
	input  wire logic       sdaIn,
	output logic            sdaOeN,
	// Device address
	input  wire logic [6:0] slaveAddr,
	// Register side
	output logic [7:0]      regAddr,
	output logic            wrStrobe,
	output logic [7:0]      wrData,
	input  wire logic [7:0] rdData
);
	lpi_pkg::lpi_i2c_state_type state, next_state;
	logic [3:0] bitCnt, next_bitCnt;
	logic [7:0] shift, next_shift;
	logic [7:0] ptr, next_ptr;
	logic       drive, next_drive;
	logic       nack, next_nack;
	logic       sclPrev, sdaPrev;
	logic       sclRise, sclFall, startCond, stopCond;

	assign sclRise   = sclIn & ~sclPrev;
	assign sclFall   = ~sclIn & sclPrev;
	assign startCond = sclIn & sclPrev & sdaPrev & ~sdaIn;
	assign stopCond  = sclIn & sclPrev & ~sdaPrev & sdaIn;
	assign sdaOeN    = ~drive;
	assign regAddr   = ptr;
	assign wrData    = shift;

	always_comb begin
		next_state  = state;
		next_bitCnt = bitCnt;
		next_shift  = shift;
		next_ptr    = ptr;
		next_drive  = drive;
		next_nack   = nack;
		wrStrobe    = 1'b0;
		if (startCond) begin
			next_state  = lpi_pkg::I2C_ADDR;
			next_bitCnt = 4'h0;
			next_drive  = 1'b0;
		end else if (stopCond) begin
			next_state = lpi_pkg::I2C_IDLE;
			next_drive = 1'b0;
		end else begin
			case (state)
				lpi_pkg::I2C_ADDR, lpi_pkg::I2C_PTR, lpi_pkg::I2C_WR: begin
					if (sclRise) begin
						next_shift  = {shift[6:0], sdaIn};
						next_bitCnt = bitCnt + 4'h1;
					end else if (sclFall && bitCnt == 4'h8) begin
						next_drive = 1'b1;
						if (state == lpi_pkg::I2C_ADDR) begin
							if (shift[7:1] == slaveAddr) begin
								next_nack  = shift[0];
								next_state = lpi_pkg::I2C_ADDR_ACK;
							end else begin
								next_drive = 1'b0;
								next_state = lpi_pkg::I2C_IDLE;
							end
						end else if (state == lpi_pkg::I2C_PTR) begin
							next_ptr   = shift;
							next_state = lpi_pkg::I2C_PTR_ACK;
						end else begin
							wrStrobe   = 1'b1;
							next_state = lpi_pkg::I2C_WR_ACK;
						end
					end
				end
				lpi_pkg::I2C_ADDR_ACK: begin
					if (sclFall) begin
						next_bitCnt = 4'h0;
						if (nack) begin
							next_shift = rdData;
							next_drive = ~rdData[7];
							next_state = lpi_pkg::I2C_RD;
						end else begin
							next_drive = 1'b0;
							next_state = lpi_pkg::I2C_PTR;
						end
					end
				end
				lpi_pkg::I2C_PTR_ACK, lpi_pkg::I2C_WR_ACK: begin
					if (sclFall) begin
						next_drive  = 1'b0;
						next_bitCnt = 4'h0;
						next_state  = lpi_pkg::I2C_WR;
						if (state == lpi_pkg::I2C_WR_ACK) begin
							next_ptr = ptr + 8'h01;
						end
					end
				end
				lpi_pkg::I2C_RD: begin
					if (sclRise) begin
						next_bitCnt = bitCnt + 4'h1;
					end else if (sclFall) begin
						if (bitCnt == 4'h8) begin
							next_drive = 1'b0;
							next_ptr   = ptr + 8'h01;
							next_state = lpi_pkg::I2C_RD_ACK;
						end else begin
							next_shift = {shift[6:0], 1'b0};
							next_drive = ~shift[6];
						end
					end
				end
				lpi_pkg::I2C_RD_ACK: begin
					if (sclRise) begin
						next_nack = sdaIn;
					end else if (sclFall) begin
						if (nack) begin
							next_state = lpi_pkg::I2C_IDLE;
						end else begin
							next_bitCnt = 4'h0;
							next_shift  = rdData;
							next_drive  = ~rdData[7];
							next_state  = lpi_pkg::I2C_RD;
						end
					end
				end
				default: begin
					next_drive = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state   <= lpi_pkg::I2C_IDLE;
			bitCnt  <= 4'h0;
			shift   <= 8'h00;
			ptr     <= 8'h00;
			drive   <= 1'b0;
			nack    <= 1'b0;
			sclPrev <= 1'b1;
			sdaPrev <= 1'b1;
		end else begin
			state   <= next_state;
			bitCnt  <= next_bitCnt;
			shift   <= next_shift;
			ptr     <= next_ptr;
			drive   <= next_drive;
			nack    <= next_nack;
			sclPrev <= sclIn;
			sdaPrev <= sdaIn;
		end
	end
endmodule

// ---- rtl/lpi_params.svh ----
// Purpose: Constants of the light and proximity interrupt logic.
// Assumes: A 10 MHz system clock.
// Notes:   Times keep their printed unit; cycle counts derive from them.
`ifndef LPI_PARAMS_SVH
`define LPI_PARAMS_SVH

`define LPI_CLK_HZ          10000000
`define LPI_ALS_PERIOD_MS   100
`define LPI_PROX_CONV_US    540
`define LPI_EMIT_ON_US      100
`define LPI_PROX_PERIOD_MS  800

`define LPI_ALS_CYCLES      (`LPI_CLK_HZ / 1000 * `LPI_ALS_PERIOD_MS)
`define LPI_PROX_CONV_CYC   (`LPI_CLK_HZ / 1000000 * `LPI_PROX_CONV_US)
`define LPI_EMIT_CYCLES     (`LPI_CLK_HZ / 1000000 * `LPI_EMIT_ON_US)
`define LPI_PROX_CYCLES     (`LPI_CLK_HZ / 1000 * `LPI_PROX_PERIOD_MS)

`define LPI_ALS_WIDTH       12
`define LPI_PROX_WIDTH      8
`define LPI_ALS_FULL        12'hFFF
`define LPI_PROX_FULL       8'hFF

// Word indices; the byte address is four times the index.
`define LPI_IDX_CTRL        3'h0
`define LPI_IDX_ALS_LO      3'h1
`define LPI_IDX_ALS_HI      3'h2
`define LPI_IDX_PROX_THR    3'h3
`define LPI_IDX_ALS_DATA    3'h4
`define LPI_IDX_PROX_DATA   3'h5
`define LPI_IDX_STATUS      3'h6
`define LPI_IDX_MASK        3'h7

`define LPI_CTRL_ALS_EN     0
`define LPI_CTRL_PROX_EN    1
`define LPI_CTRL_PERS_LO    2
`define LPI_CTRL_BOTH       4
`define LPI_CTRL_BITS       5

`define LPI_ST_ALS          0
`define LPI_ST_PROX         1
`define LPI_ST_BOTH         2
`define LPI_ST_ALS_DONE     3
`define LPI_ST_PROX_DONE    4
`define LPI_ST_BITS         5

`define LPI_RST_CTRL        5'h00
`define LPI_RST_ALS_LO      12'h000
`define LPI_RST_ALS_HI      12'hFFF
`define LPI_RST_PROX_THR    8'hFF
`define LPI_RST_MASK        5'h00

`define LPI_BASE_ADDR       7'h44
`endif

// ---- rtl/lpi_pkg.sv ----
// Purpose: Types shared by the light and proximity interrupt logic.
// Assumes: Nothing.
// Notes:   Constants live in lpi_params.svh.
package lpi_pkg;
	typedef enum logic [3:0] {
		I2C_IDLE, I2C_ADDR, I2C_ADDR_ACK, I2C_PTR, I2C_PTR_ACK,
		I2C_WR, I2C_WR_ACK, I2C_RD, I2C_RD_ACK
	} lpi_i2c_state_type;
endpackage

// ---- rtl/lpi_sensor_core.sv ----
// Purpose: Conversion sequencing, thresholds, persistence and interrupts of the sensor.
// Assumes: Converter raw results arrive on clk_sys; bus pins come from outside.
// Notes:   Registers are reachable over APB and over the serial-bus slave.
// Functional notes
// - Ambient and proximity conversions run on separate timers, never waiting for each other.
// - The ambient converter delivers one sample every 100 ms.
// - Each proximity cycle fires the emitter driver and converts for 540 us.
// - The emitter is on for 100 us per cycle and cycles repeat every 800 ms.
// - An interrupt event drives the interrupt pin and sets readable status bits; here the pin follows only status bits whose mask bit is set.
// - An ambient result below the low or above the high threshold is a trigger.
// - A proximity result above its threshold is a trigger.
// - Each channel has its own programmable threshold registers.
// - Persistence of 1, 4, 8 or 16 consecutive triggers is needed before an interrupt.
// - In combined mode only simultaneous ambient and proximity triggers interrupt; the conversion-done events still reach the pin too.
// - The interrupt pin is open drain, pulling low only while asserted.
// - The host reaches the device over the serial bus with the device as slave.
// - Results are 12-bit and 8-bit counts that saturate at full scale.
// - With both enables clear all conversions and emitter pulses stop.
//
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "lpi_params.svh"
module lpi_sensor_core #(
	parameter int ALS_CYCLES  = `LPI_ALS_CYCLES,
	parameter int PROX_CONV   = `LPI_PROX_CONV_CYC,
	parameter int PROX_CYCLES = `LPI_PROX_CYCLES,
	parameter int EMIT_CYCLES = `LPI_EMIT_CYCLES
) (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        reset,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Converter raw results
	input  wire logic [15:0] alsRaw,
	input  wire logic [15:0] proxRaw,
	// Serial bus and address select
	input  wire logic        sclIn,
	input  wire logic        sdaIn,
	output logic             sdaOut,
	output logic             sdaOeN,
	input  wire logic        slaveAddrSelectPin,
	// Emitter driver and interrupt
	output logic             emitterSinkDriverPin,
	output logic             irqPinOut,
	output logic             irqPinOeN,
	output logic             irq
);
	localparam logic [23:0] ALS_LAST  = 24'(ALS_CYCLES - 1);
	localparam logic [23:0] PROX_LAST = 24'(PROX_CYCLES - 1);
	localparam logic [23:0] CONV_LAST = 24'(PROX_CONV - 1);
	localparam logic [23:0] EMIT_END  = 24'(EMIT_CYCLES);

	logic [`LPI_CTRL_BITS-1:0] ctrl, next_ctrl;
	logic [11:0] alsLo, next_alsLo, alsHi, next_alsHi, alsData, next_alsData;
	logic [7:0]  proxThr, next_proxThr, proxData, next_proxData;
	logic [`LPI_ST_BITS-1:0] status, next_status, mask, next_mask, setBits, gate;
	logic [23:0] alsTimer, next_alsTimer, proxTimer, next_proxTimer;
	logic [4:0]  alsCnt, next_alsCnt, proxCnt, next_proxCnt, bothCnt, next_bothCnt;
	logic [4:0]  persist;
	logic        alsTrig, next_alsTrig, proxTrig, next_proxTrig;
	logic        emitter, next_emitter;
	logic [31:0] next_prdata;
	logic [1:0]  sclSync, sdaSync, addrSync;
	logic        alsDone, proxDone, apbWrite, i2cWrite, wrEn;
	logic [2:0]  wrIdx;
	logic [31:0] wrData, wrMask, i2cWord;
	logic [7:0]  i2cAddr, i2cWrData, i2cRdData;
	logic [11:0] alsSat;
	logic [7:0]  proxSat;

	function automatic logic [31:0] regRead(input logic [2:0] idx,
		input logic [`LPI_CTRL_BITS-1:0] c, input logic [11:0] lo, input logic [11:0] hi,
		input logic [7:0] pt, input logic [11:0] ad, input logic [7:0] pd,
		input logic [`LPI_ST_BITS-1:0] st, input logic [`LPI_ST_BITS-1:0] mk);
		logic [31:0] value;
		value = 32'h0000_0000;
		case (idx)
			`LPI_IDX_CTRL:      value = 32'(c);
			`LPI_IDX_ALS_LO:    value = 32'(lo);
			`LPI_IDX_ALS_HI:    value = 32'(hi);
			`LPI_IDX_PROX_THR:  value = 32'(pt);
			`LPI_IDX_ALS_DATA:  value = 32'(ad);
			`LPI_IDX_PROX_DATA: value = 32'(pd);
			`LPI_IDX_STATUS:    value = 32'(st);
			`LPI_IDX_MASK:      value = 32'(mk);
			default:            value = 32'h0000_0000;
		endcase
		return value;
	endfunction

	// The serial bus stays a level input: two flops, then the slave finds the edges.
	lpi_i2c_slave u_i2c (
		.clk_sys   (clk_sys),
		.reset     (reset),
		.sclIn     (sclSync[1]),
		.sdaIn     (sdaSync[1]),
		.sdaOeN    (sdaOeN),
		.slaveAddr (7'({`LPI_BASE_ADDR >> 1, addrSync[1]})),
		.regAddr   (i2cAddr),
		.wrStrobe  (i2cWrite),
		.wrData    (i2cWrData),
		.rdData    (i2cRdData)
	);

	assign sdaOut    = 1'b0;
	assign pready    = 1'b1;
	assign pslverr   = psel & penable & (paddr[7:5] != 3'h0 || paddr[1:0] != 2'h0);
	assign apbWrite  = psel & penable & pwrite & ~pslverr;
	assign i2cWord   = regRead(i2cAddr[4:2], ctrl, alsLo, alsHi, proxThr, alsData,
		proxData, status, mask);
	assign i2cRdData = (i2cAddr[7:5] != 3'h0) ? 8'h00 : i2cWord[8*i2cAddr[1:0] +: 8];
	assign emitterSinkDriverPin = emitter;
	assign irqPinOut = 1'b0;

	// Saturate the raw converter counts at full scale.
	assign alsSat  = (alsRaw > 16'(`LPI_ALS_FULL)) ? `LPI_ALS_FULL : alsRaw[11:0];
	assign proxSat = (proxRaw > 16'(`LPI_PROX_FULL)) ? `LPI_PROX_FULL : proxRaw[7:0];

	// APB wins a collision with a serial-bus byte write; that byte is lost.
	always_comb begin
		wrEn   = apbWrite | i2cWrite;
		wrIdx  = apbWrite ? paddr[4:2] : i2cAddr[4:2];
		wrData = apbWrite ? pwdata : {4{i2cWrData}};
		wrMask = apbWrite ? 32'hFFFF_FFFF : (32'h0000_00FF << (8 * i2cAddr[1:0]));
		if (!apbWrite && i2cAddr[7:5] != 3'h0) begin
			wrEn = 1'b0;
		end
		case (ctrl[`LPI_CTRL_PERS_LO +: 2])
			2'h0:    persist = 5'h01;
			2'h1:    persist = 5'h04;
			2'h2:    persist = 5'h08;
			default: persist = 5'h10;
		endcase
	end

	always_comb begin
		next_ctrl     = ctrl;
		next_alsLo    = alsLo;
		next_alsHi    = alsHi;
		next_proxThr  = proxThr;
		next_mask     = mask;
		next_alsData  = alsData;
		next_proxData = proxData;
		next_alsTrig  = alsTrig;
		next_proxTrig = proxTrig;
		next_alsCnt   = alsCnt;
		next_proxCnt  = proxCnt;
		next_bothCnt  = bothCnt;
		setBits       = '0;
		next_status   = status;
		next_prdata   = regRead(paddr[4:2], ctrl, alsLo, alsHi, proxThr, alsData,
			proxData, status, mask);
		if (paddr[7:5] != 3'h0 || paddr[1:0] != 2'h0) begin
			next_prdata = 32'h0000_0000;
		end
		// Separate thresholds per channel.
		if (wrEn) begin
			case (wrIdx)
				`LPI_IDX_CTRL:     next_ctrl = (ctrl & ~wrMask[4:0]) | (wrData[4:0] & wrMask[4:0]);
				`LPI_IDX_ALS_LO:   next_alsLo = (alsLo & ~wrMask[11:0]) | (wrData[11:0] & wrMask[11:0]);
				`LPI_IDX_ALS_HI:   next_alsHi = (alsHi & ~wrMask[11:0]) | (wrData[11:0] & wrMask[11:0]);
				`LPI_IDX_PROX_THR: next_proxThr = (proxThr & ~wrMask[7:0]) | (wrData[7:0] & wrMask[7:0]);
				`LPI_IDX_STATUS:   next_status = status & ~(wrData[4:0] & wrMask[4:0]);
				`LPI_IDX_MASK:     next_mask = (mask & ~wrMask[4:0]) | (wrData[4:0] & wrMask[4:0]);
				default:           next_status = next_status;
			endcase
		end
		if (alsDone) begin
			next_alsData = alsSat;
			next_alsTrig = (alsSat < alsLo) || (alsSat > alsHi);
			setBits[`LPI_ST_ALS_DONE] = 1'b1;
			next_alsCnt = next_alsTrig ? ((alsCnt < 5'h10) ? alsCnt + 5'h01 : alsCnt) : 5'h00;
			setBits[`LPI_ST_ALS] = next_alsTrig && next_alsCnt >= persist;
		end
		if (proxDone) begin
			next_proxData = proxSat;
			next_proxTrig = proxSat > proxThr;
			setBits[`LPI_ST_PROX_DONE] = 1'b1;
			next_proxCnt = next_proxTrig ? ((proxCnt < 5'h10) ? proxCnt + 5'h01 : proxCnt) : 5'h00;
			setBits[`LPI_ST_PROX] = next_proxTrig && next_proxCnt >= persist;
		end
		// Combined count steps or clears once in each cycle in which either channel completes a measurement.
		if (alsDone || proxDone) begin
			if (next_alsTrig && next_proxTrig) begin
				next_bothCnt = (bothCnt < 5'h10) ? bothCnt + 5'h01 : bothCnt;
			end else begin
				next_bothCnt = 5'h00;
			end
			setBits[`LPI_ST_BOTH] = next_alsTrig && next_proxTrig && next_bothCnt >= persist;
		end
		// A new event wins over a clear written in the same cycle.
		next_status = next_status | setBits;
	end

	// Independent timers for the two converters.
	always_comb begin
		alsDone        = 1'b0;
		proxDone       = 1'b0;
		next_alsTimer  = 24'h00_0000;
		next_proxTimer = 24'h00_0000;
		next_emitter   = 1'b0;
		if (ctrl[`LPI_CTRL_ALS_EN]) begin
			alsDone       = (alsTimer == ALS_LAST);
			next_alsTimer = alsDone ? 24'h00_0000 : alsTimer + 24'h00_0001;
		end
		if (ctrl[`LPI_CTRL_PROX_EN]) begin
			proxDone       = (proxTimer == CONV_LAST);
			next_proxTimer = (proxTimer == PROX_LAST) ? 24'h00_0000 : proxTimer + 24'h00_0001;
			next_emitter   = (proxTimer < EMIT_END);
		end
		// Both enables clear leaves timers and emitter at rest.
	end

	// Combined mode blocks the single-channel events; the joint and conversion-done events reach the pin.
	assign gate = ctrl[`LPI_CTRL_BOTH] ? 5'b11100 : 5'b11011;
	assign irq = |(status & mask & gate);
	assign irqPinOeN = ~irq;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ctrl      <= `LPI_RST_CTRL;
			alsLo     <= `LPI_RST_ALS_LO;
			alsHi     <= `LPI_RST_ALS_HI;
			proxThr   <= `LPI_RST_PROX_THR;
			mask      <= `LPI_RST_MASK;
			status    <= '0;
			alsData   <= 12'h000;
			proxData  <= 8'h00;
			alsTrig   <= 1'b0;
			proxTrig  <= 1'b0;
			alsCnt    <= 5'h00;
			proxCnt   <= 5'h00;
			bothCnt   <= 5'h00;
			alsTimer  <= 24'h00_0000;
			proxTimer <= 24'h00_0000;
			emitter   <= 1'b0;
			prdata    <= 32'h0000_0000;
			sclSync   <= 2'h3;
			sdaSync   <= 2'h3;
			addrSync  <= 2'h0;
		end else begin
			ctrl      <= next_ctrl;
			alsLo     <= next_alsLo;
			alsHi     <= next_alsHi;
			proxThr   <= next_proxThr;
			mask      <= next_mask;
			status    <= next_status;
			alsData   <= next_alsData;
			proxData  <= next_proxData;
			alsTrig   <= next_alsTrig;
			proxTrig  <= next_proxTrig;
			alsCnt    <= next_alsCnt;
			proxCnt   <= next_proxCnt;
			bothCnt   <= next_bothCnt;
			alsTimer  <= next_alsTimer;
			proxTimer <= next_proxTimer;
			emitter   <= next_emitter;
			prdata    <= next_prdata;
			sclSync   <= {sclSync[0], sclIn};
			sdaSync   <= {sdaSync[0], sdaIn};
			addrSync  <= {addrSync[0], slaveAddrSelectPin};
		end
	end
endmodule

// ---- sim/light_proximity_interrupt_logic_test.sv ----
// Purpose: Self-checking bench of the sensor core.
// Assumes: 10 MHz clock and shortened conversion timers.
// Notes:   Ambient sample waits poll status and emitter waits poll the pin, so timer slack does not break them; other waits count fixed cycles.
`timescale 1ns/1ps
module light_proximity_interrupt_logic_test;
	localparam int AC = 200;
	localparam int PC = 40;
	localparam int PP = 300;
	localparam int EC = 10;
	localparam logic [7:0] CT = 8'h00, LO = 8'h04, HI = 8'h08, TH = 8'h0C;
	localparam logic [7:0] AD = 8'h10, PD = 8'h14, ST = 8'h18, MK = 8'h1C;
	logic        clk_sys = 1'b0;
	logic        reset = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [15:0] alsRaw = 16'h0400;
	logic [15:0] proxRaw = 16'h0010;
	logic        slaveAddrSelectPin = 1'b1;
	logic        scl;
	logic        hostDrvN;
	logic [31:0] prdata;
	logic        pready, pslverr, sdaOut, sdaOeN;
	logic        emitterSinkDriverPin, irqPinOut, irqPinOeN, irq;
	wire         sda = hostDrvN & sdaOeN;
	int          err_count = 0;
	int          samples_checked = 0;
	int          cyc = 0;
	lpi_sensor_core #(.ALS_CYCLES(AC), .PROX_CONV(PC), .PROX_CYCLES(PP), .EMIT_CYCLES(EC)) i_dut (
		.clk_sys, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .alsRaw, .proxRaw, .sclIn(scl), .sdaIn(sda), .sdaOut, .sdaOeN,
		.slaveAddrSelectPin, .emitterSinkDriverPin, .irqPinOut, .irqPinOeN, .irq);
	lpi_host_model i_host (.clk_sys(clk_sys), .scl(scl), .sdaDrvN(hostDrvN), .sda(sda));
	always #50 clk_sys = ~clk_sys;
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 40000) begin
			err_count++;
			end_of_test();
		end
	end
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	// The request holds until pready is sampled high; the extra edge keeps drives apart.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 50);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		logic e;
		apb(1'b0, a, 32'h0, r, e);
	endtask
	task automatic als_sample(output logic [31:0] s);
		int n;
		n = 0;
		do begin
			rd(ST, s);
			n++;
		end while (s[3] !== 1'b1 && n < 200);
		tick(2);
		rd(ST, s);
		wr(ST, 32'h1F);
	endtask
	task automatic t_reg;
		logic [31:0] s;
		logic e;
		logic [7:0] a [6];
		logic [31:0] v [6];
		a = '{CT, LO, HI, TH, ST, MK};
		v = '{32'h0, 32'h0, 32'hFFF, 32'hFF, 32'h0, 32'h0};
		for (int i = 0; i < 6; i++) begin
			rd(a[i], s);
			chk("reset value", s, v[i]);
		end
		chk("irq pin idle", 32'(irqPinOeN), 32'h1);
		apb(1'b0, 8'h20, 32'h0, s, e);
		chk("unmapped err", 32'(e), 32'h1);
		apb(1'b0, 8'h0A, 32'h0, s, e);
		chk("misaligned err", 32'(e), 32'h1);
		chk("refused data", s, 32'h0);
		wr(TH, 32'h5A);
		wr(AD, 32'hABC);
		rd(LO, s);
		chk("als low kept", s, 32'h0);
		rd(TH, s);
		chk("prox threshold", s, 32'h5A);
		rd(AD, s);
		chk("als data read only", s, 32'h0);
	endtask
	task automatic t_i2c;
		logic ok;
		logic [31:0] s;
		i_host.wr_reg(7'h44, 8'h00, 8'h03, ok);
		chk("other address", 32'(ok), 32'h0);
		i_host.wr_reg(7'h45, 8'h00, 8'h03, ok);
		chk("own address", 32'(ok), 32'h1);
		rd(CT, s);
		chk("serial write", s, 32'h3);
		wr(CT, 32'h0);
		tick(10);
	endtask
	task automatic t_irq;
		logic [31:0] s;
		alsRaw <= 16'h0900;
		wr(LO, 32'h100);
		wr(HI, 32'h800);
		wr(ST, 32'h1F);
		wr(CT, 32'h01);
		tick(AC + 20);
		rd(ST, s);
		chk("als flag", 32'(s[0]), 32'h1);
		chk("masked irq", 32'(irq), 32'h0);
		alsRaw <= 16'h0400;
		wr(MK, 32'h01);
		chk("irq", 32'(irq), 32'h1);
		chk("irq pin", 32'(irqPinOeN), 32'h0);
		tick(2 * AC);
		chk("irq held", 32'(irq), 32'h1);
		wr(ST, 32'h1F);
		chk("irq cleared", 32'(irq), 32'h0);
		chk("pin released", 32'(irqPinOeN), 32'h1);
		wr(CT, 32'h0);
		wr(MK, 32'h0);
	endtask
	task automatic t_pers;
		logic [31:0] s;
		logic [15:0] trig [4];
		int n;
		trig = '{16'h0900, 16'h0050, 16'hFFFF, 16'h0900};
		wr(CT, 32'h01);
		tick(AC - 12);
		rd(ST, s);
		chk("als early", 32'(s[3]), 32'h0);
		tick(12);
		rd(ST, s);
		chk("als on time", 32'(s[3]), 32'h1);
		wr(ST, 32'h1F);
		for (int c = 0; c < 4; c++) begin
			wr(CT, 32'h01 | (c << 2));
			alsRaw <= 16'h0400;
			als_sample(s);
			als_sample(s);
			chk("in window", 32'(s[0]), 32'h0);
			alsRaw <= trig[c];
			n = 0;
			do begin
				als_sample(s);
				n++;
			end while (s[0] !== 1'b1 && n < 20);
			chk("persistence", 32'(n), (c == 0) ? 32'h1 : 32'h2 << c);
			if (c == 2) begin
				rd(AD, s);
				chk("als saturates", s, 32'hFFF);
			end
		end
		wr(CT, 32'h0);
		tick(10);
	endtask
	task automatic t_prox;
		logic [31:0] s;
		int h;
		int p;
		proxRaw <= 16'h0123;
		wr(TH, 32'h80);
		wr(ST, 32'h1F);
		wr(CT, 32'h02);
		for (p = 0; emitterSinkDriverPin !== 1'b1 && p < 50; p++) tick(1);
		for (h = 0; emitterSinkDriverPin === 1'b1 && h < 50; h++) tick(1);
		for (p = h; emitterSinkDriverPin !== 1'b1 && p < 400; p++) tick(1);
		chk("emitter on", 32'(h), 32'(EC));
		chk("emitter period", 32'(p), 32'(PP));
		rd(ST, s);
		chk("prox flags", s & 32'h12, 32'h12);
		rd(PD, s);
		chk("prox saturates", s, 32'hFF);
		proxRaw <= 16'h0080;
		tick(PC + 5);
		wr(ST, 32'h1F);
		tick(PP);
		rd(ST, s);
		chk("prox at threshold", s & 32'h12, 32'h10);
		wr(CT, 32'h0);
		tick(10);
	endtask
	task automatic t_both;
		logic [31:0] s;
		alsRaw <= 16'h0900;
		proxRaw <= 16'h0090;
		wr(MK, 32'h04);
		wr(ST, 32'h1F);
		wr(CT, 32'h13);
		tick(AC + 30);
		rd(ST, s);
		chk("both converters", s & 32'h1C, 32'h1C);
		chk("combined irq", 32'(irq), 32'h1);
		proxRaw <= 16'h0010;
		tick(PP + 10);
		wr(ST, 32'h1F);
		tick(AC + 20);
		rd(ST, s);
		chk("als alone", 32'(s[2]), 32'h0);
		chk("no combined irq", 32'(irq), 32'h0);
		wr(CT, 32'h0);
		wr(MK, 32'h0);
	endtask
	task automatic t_off;
		logic [31:0] s;
		int h;
		tick(10);
		wr(ST, 32'h1F);
		h = 0;
		repeat (700) begin
			tick(1);
			h += emitterSinkDriverPin;
		end
		chk("emitter idle", 32'(h), 32'h0);
		rd(ST, s);
		chk("no conversions", s, 32'h0);
	endtask
	initial begin
		tick(8);
		reset <= 1'b0;
		tick(1);
		t_reg();
		$display("test reg done, mismatches %0d", err_count);
		t_i2c();
		$display("test serial done, mismatches %0d", err_count);
		t_irq();
		$display("test irq done, mismatches %0d", err_count);
		t_pers();
		$display("test persistence done, mismatches %0d", err_count);
		t_prox();
		$display("test prox done, mismatches %0d", err_count);
		t_both();
		$display("test combined done, mismatches %0d", err_count);
		t_off();
		$display("test off done, mismatches %0d", err_count);
		end_of_test();
	end
endmodule

// ---- sim/lpi_core_assertions.sv ----
// Purpose: Port-level checks of the sensor core.
// Assumes: One clock domain with a synchronous reset.
// Notes:   Bound into every instance of the core.
`timescale 1ns/1ps
module lpi_core_assertions #(
	parameter int EMIT_CYCLES = 10
) (
	// Clock and reset
	input wire logic        clk_sys,
	input wire logic        reset,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Pins
	input wire logic        sclIn,
	input wire logic        sdaOut,
	input wire logic        emitterSinkDriverPin,
	input wire logic        irqPinOut,
	input wire logic        irqPinOeN,
	input wire logic        irq
);
	logic [15:0] onCnt;
	logic [15:0] next_onCnt;
	logic [5:0]  quiet;
	logic [5:0]  next_quiet;
	logic        sclLast;
	wire         acc = psel && penable;
	wire         bad = (paddr[7:5] != 3'h0) || (paddr[1:0] != 2'h0);
	wire         off = acc && pwrite && !bad && paddr[4:2] == 3'h0 && pwdata[1:0] == 2'h0;
	// A serial-bus write may also clear status, so recent bus activity excuses a fall.
	always_comb begin
		next_onCnt = emitterSinkDriverPin ? onCnt + 16'h0001 : 16'h0000;
		next_quiet = (sclIn != sclLast) ? 6'h00 : quiet + {5'h00, quiet != 6'h3F};
	end
	always_ff @(posedge clk_sys) begin
		onCnt <= reset ? 16'h0000 : next_onCnt;
		quiet <= reset ? 6'h3F : next_quiet;
		sclLast <= sclIn;
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	sequence s_ctrl_off;
		off;
	endsequence
	sequence s_emit_quiet;
		!emitterSinkDriverPin [*4];
	endsequence
	a_zero_wait: assert property (acc |-> pready) else $error("pready low in access");
	a_addr_err: assert property (acc |-> pslverr == bad) else $error("pslverr wrong");
	a_err_rdata: assert property (acc && !pwrite && bad |-> prdata == 32'h0)
		else $error("refused read data not zero");
	a_emit_width: assert property (onCnt <= EMIT_CYCLES)
		else $error("emitter on too long");
	a_emit_stop: assert property (s_ctrl_off |=> ##1 s_emit_quiet)
		else $error("emitter runs after power down");
	a_irq_pin: assert property (irqPinOeN == !irq && irqPinOut == 1'b0)
		else $error("interrupt pin disagrees with irq");
	a_irq_sticky: assert property ($fell(irq) |-> $past(acc && pwrite) || quiet != 6'h3F)
		else $error("irq fell without a host write");
	a_sda_low: assert property (sdaOut == 1'b0)
		else $error("serial data driven high");
endmodule
bind lpi_sensor_core lpi_core_assertions #(.EMIT_CYCLES(EMIT_CYCLES)) i_chk (
	.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.sclIn(sclIn), .sdaOut(sdaOut), .emitterSinkDriverPin(emitterSinkDriverPin),
	.irqPinOut(irqPinOut), .irqPinOeN(irqPinOeN), .irq(irq));

// ---- sim/lpi_host_model.sv ----
// Purpose: Serial-bus host that writes device registers.
// Assumes: An 800 ns bus clock, four quarters of two system clocks.
// Notes:   The bus clock stands high between frames.
`timescale 1ns/1ps
module lpi_host_model (
	// Clock
	input  wire logic clk_sys,
	// Bus lines: scl driven directly, sda pulled low while sdaDrvN is low
	output logic      scl,
	output logic      sdaDrvN,
	input  wire logic sda
);
	initial begin
		scl = 1'b1;
		sdaDrvN = 1'b1;
	end
	task automatic q;
		repeat (2) @(posedge clk_sys);
	endtask
	// Data moves only while the host holds the clock low.
	task automatic bit_io(input logic b, output logic r);
		sdaDrvN <= b;
		q();
		scl <= 1'b1;
		q();
		r = sda;
		q();
		scl <= 1'b0;
		q();
	endtask
	task automatic byte_io(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask
	task automatic wr_reg(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
		output logic ok);
		logic k0;
		logic k1;
		logic k2;
		k1 = 1'b0;
		k2 = 1'b0;
		sdaDrvN <= 1'b0;
		q();
		scl <= 1'b0;
		q();
		byte_io({a, 1'b0}, k0);
		if (k0) begin
			byte_io(p, k1);
			byte_io(d, k2);
		end
		sdaDrvN <= 1'b0;
		q();
		scl <= 1'b1;
		q();
		sdaDrvN <= 1'b1;
		q();
		ok = k0 && k1 && k2;
	endtask
endmodule
